/* hdl/cascadable_timer_control_status.sv */
// Operation
// - upper select 000 cascades on lower overflow
// - upper 100 div32, 111 subclock div4
// - lower level bit drives lower pin immediately
// - lower select 000 counts event edges
// - lower 100/101/110/111 give div32/16/4/sub4
// - event edge from external edge select
// - pin function switch may add count
// - software writes never set status flags
// - flag clears after read-one, write-zero
// - upper wrap sets upper overflow flag
// - upper match sets upper match flag
// - upper overflow request gated by enable
// - upper clear select clears on match
// - lower wrap sets lower overflow flag
// - lower match sets lower match flag in split mode only
// - lower overflow request gated by enable
// - status register resets to zero
// - lower clear select clears lower counter in split mode only
// - upper level bit drives upper pin immediately
// - control register write-only, resets zero
`timescale 1ns/1ps
`include "timer_params.svh"

module cascadable_timer_control_status
  import timer_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  // pins and interrupt-controller side inputs
  input wire logic event_input_pin,
  input wire logic event_edge_select,
  input wire logic event_pin_function_select,
  input wire logic sub_clk_in,
  // outputs
  output logic upper_toggle_pin,
  output logic lower_toggle_pin,
  output logic upper_overflow_irq,
  output logic lower_overflow_irq,
  output logic upper_match_irq,
  output logic lower_match_irq
);

  logic [1:0] rst_sync_r;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  logic tick_div32;
  logic tick_div16;
  logic tick_div4;
  logic tick_sub_div4;
  logic [3:0] rate_ticks;

  assign rate_ticks = {tick_sub_div4, tick_div4, tick_div16, tick_div32};

  clock_prescaler #(
    .DIV_W(5)
  ) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .sub_clk_in(sub_clk_in),
    .tick_div32(tick_div32),
    .tick_div16(tick_div16),
    .tick_div4(tick_div4),
    .tick_sub_div4(tick_sub_div4)
  );

  // map a clock select code to its count tick; rates passed in so callers see every change
  function automatic logic sel_tick(input logic [2:0] sel, input logic ev,
                                    input logic [3:0] rate);
    logic t;
    t = 1'b0;
    case (sel)
      `SEL_CASCADE_OR_EVENT: t = ev;
      `SEL_DIV32: t = rate[0];
      `SEL_DIV16: t = rate[1];
      `SEL_DIV4: t = rate[2];
      `SEL_SUB_DIV4: t = rate[3];
      default: t = 1'b0;
    endcase
    return t;
  endfunction : sel_tick

  timer_state_t s_r;
  timer_state_t s_nxt;

  logic split;
  logic ev_gated;
  logic ev_edge;
  logic l_tick;
  logic u_tick;
  logic l_match;
  logic j_match;
  logic u_match;
  logic l_clr;
  logic u_clr;
  logic l_wrap;
  logic u_wrap;
  logic wr_ctrl;
  logic wr_stat;
  logic rd_stat;
  logic [3:0] flag_evt;
  logic [3:0] flag_cur;
  logic [3:0] flag_wbit;

  assign split = s_r.ctrl[`BIT_UPPER_SPLIT];
  assign wr_ctrl = wr && (addr == `ADDR_CLOCK_LEVEL_CONTROL);
  assign wr_stat = wr && (addr == `ADDR_FLAG_ENABLE_STATUS);
  assign rd_stat = rd && (addr == `ADDR_FLAG_ENABLE_STATUS);

  // pin idles high while its function is off; a switch on while low makes a falling edge
  assign ev_gated = event_pin_function_select ? event_input_pin : 1'b1;
  assign ev_edge = event_edge_select ? (ev_gated && !s_r.ev_prev)
                                     : (!ev_gated && s_r.ev_prev);

  assign l_tick = sel_tick(s_r.ctrl[2:0], ev_edge, rate_ticks);
  assign l_match = l_tick && (s_r.lower_count == s_r.lower_compare_value);
  assign j_match = l_tick && ({s_r.upper_count, s_r.lower_count} ==
                              {s_r.upper_compare_value, s_r.lower_compare_value});
  assign l_clr = split ? (l_match && s_r.stat[`BIT_LOWER_MATCH_CLEAR_ENABLE])
                       : (j_match && s_r.stat[`BIT_UPPER_MATCH_CLEAR_ENABLE]);
  assign l_wrap = l_tick && (s_r.lower_count == 8'hFF) && !l_clr;
  // split mode: upper codes 1xx run on internal rates, 0xx give no tick
  assign u_tick = split ? sel_tick(s_r.ctrl[6:4], 1'b0, rate_ticks) : l_wrap;
  assign u_match = split ? (u_tick && (s_r.upper_count == s_r.upper_compare_value)) : j_match;
  assign u_clr = split ? (u_match && s_r.stat[`BIT_UPPER_MATCH_CLEAR_ENABLE]) : l_clr;
  assign u_wrap = u_tick && (s_r.upper_count == 8'hFF) && !u_clr;

  assign flag_evt = {u_wrap, u_match, l_wrap, l_match && split};
  assign flag_cur = {s_r.stat[`BIT_UPPER_OVERFLOW_FLAG], s_r.stat[`BIT_UPPER_MATCH_FLAG],
                     s_r.stat[`BIT_LOWER_OVERFLOW_FLAG], s_r.stat[`BIT_LOWER_MATCH_FLAG]};
  assign flag_wbit = {wdata[`BIT_UPPER_OVERFLOW_FLAG], wdata[`BIT_UPPER_MATCH_FLAG],
                      wdata[`BIT_LOWER_OVERFLOW_FLAG], wdata[`BIT_LOWER_MATCH_FLAG]};

  always_comb begin
    logic [3:0] flag_nxt;
    flag_nxt = flag_cur;
    s_nxt = s_r;
    s_nxt.ev_prev = ev_gated;

    // counters: hardware first, a software write overrides
    if (l_tick) begin
      s_nxt.lower_count = l_clr ? 8'h00 : s_r.lower_count + 8'h01;
    end
    if (u_tick || u_clr) begin
      s_nxt.upper_count = u_clr ? 8'h00 : s_r.upper_count + 8'h01;
    end
    if (wr && addr == `ADDR_UPPER_COUNT) begin
      s_nxt.upper_count = wdata;
    end
    if (wr && addr == `ADDR_LOWER_COUNT) begin
      s_nxt.lower_count = wdata;
    end
    if (wr && addr == `ADDR_UPPER_COMPARE) begin
      s_nxt.upper_compare_value = wdata;
    end
    if (wr && addr == `ADDR_LOWER_COMPARE) begin
      s_nxt.lower_compare_value = wdata;
    end

    // toggle pins: a compare match toggles, a control write sets the level
    if (u_match) begin
      s_nxt.upper_toggle_pin = !s_r.upper_toggle_pin;
    end
    if (l_match && split) begin
      s_nxt.lower_toggle_pin = !s_r.lower_toggle_pin;
    end
    if (wr_ctrl) begin
      s_nxt.ctrl = wdata;
      s_nxt.upper_toggle_pin = wdata[`BIT_UPPER_TOGGLE_LEVEL];
      s_nxt.lower_toggle_pin = wdata[`BIT_LOWER_TOGGLE_LEVEL];
    end

    // flags: zero write clears only after a read of one; a set wins
    if (wr_stat) begin
      flag_nxt = flag_cur & ~(~flag_wbit & s_r.seen);
      s_nxt.seen = 4'h0;
      s_nxt.stat = (s_r.stat & ~`STATUS_WRITABLE_MASK) | (wdata & `STATUS_WRITABLE_MASK);
    end else if (rd_stat) begin
      s_nxt.seen = s_r.seen | flag_cur;
    end
    flag_nxt = flag_nxt | flag_evt;
    s_nxt.stat[`BIT_UPPER_OVERFLOW_FLAG] = flag_nxt[3];
    s_nxt.stat[`BIT_UPPER_MATCH_FLAG] = flag_nxt[2];
    s_nxt.stat[`BIT_LOWER_OVERFLOW_FLAG] = flag_nxt[1];
    s_nxt.stat[`BIT_LOWER_MATCH_FLAG] = flag_nxt[0];

    // request pulses toward the interrupt controller
    s_nxt.upper_ovf_req = u_wrap && s_r.stat[`BIT_UPPER_OVERFLOW_IRQ_ENABLE];
    s_nxt.lower_ovf_req = l_wrap && s_r.stat[`BIT_LOWER_OVERFLOW_IRQ_ENABLE];
    s_nxt.upper_match_req = u_match;
    s_nxt.lower_match_req = l_match && split;

    // read data; the control register reads as zero
    s_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADDR_FLAG_ENABLE_STATUS: s_nxt.rdata = s_r.stat;
        `ADDR_UPPER_COUNT: s_nxt.rdata = s_r.upper_count;
        `ADDR_LOWER_COUNT: s_nxt.rdata = s_r.lower_count;
        `ADDR_UPPER_COMPARE: s_nxt.rdata = s_r.upper_compare_value;
        `ADDR_LOWER_COMPARE: s_nxt.rdata = s_r.lower_compare_value;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ctrl <= `RST_CONTROL;
      s_r.stat <= `RST_STATUS;
      s_r.upper_count <= `RST_COUNT;
      s_r.lower_count <= `RST_COUNT;
      s_r.upper_compare_value <= `RST_COMPARE;
      s_r.lower_compare_value <= `RST_COMPARE;
      s_r.ev_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = s_r.rdata;
  assign upper_toggle_pin = s_r.upper_toggle_pin;
  assign lower_toggle_pin = s_r.lower_toggle_pin;
  assign upper_overflow_irq = s_r.upper_ovf_req;
  assign lower_overflow_irq = s_r.lower_ovf_req;
  assign upper_match_irq = s_r.upper_match_req;
  assign lower_match_irq = s_r.lower_match_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  lower_level_write_a: assert property (
    wr_ctrl |=> (lower_toggle_pin == $past(wdata[`BIT_LOWER_TOGGLE_LEVEL])))
    else $error("lower toggle pin does not follow written level");

  upper_level_write_a: assert property (
    wr_ctrl |=> (upper_toggle_pin == $past(wdata[`BIT_UPPER_TOGGLE_LEVEL])))
    else $error("upper toggle pin does not follow written level");

  ctrl_reads_zero_a: assert property (
    (rd && addr == `ADDR_CLOCK_LEVEL_CONTROL) |=> (rdata == 8'h00))
    else $error("control register read not zero");

  upper_no_set_a: assert property (
    (wr_stat && !flag_cur[3] && !flag_evt[3]) |=> !s_r.stat[`BIT_UPPER_OVERFLOW_FLAG])
    else $error("software set upper overflow flag");

  clear_needs_read_a: assert property (
    (wr_stat && flag_cur[1] && !s_r.seen[1]) |=> s_r.stat[`BIT_LOWER_OVERFLOW_FLAG])
    else $error("flag cleared without prior read of one");

  read_then_clear_a: assert property (
    (rd_stat && flag_cur[2] && !flag_evt[2]) ##1 (wr_stat && !wdata[`BIT_UPPER_MATCH_FLAG]
      && !flag_evt[2]) |=> !s_r.stat[`BIT_UPPER_MATCH_FLAG])
    else $error("upper match flag not cleared after read and zero write");

  lower_wrap_flag_a: assert property (
    (l_tick && s_r.lower_count == 8'hFF && !l_clr) |=>
      (s_r.stat[`BIT_LOWER_OVERFLOW_FLAG] && s_r.lower_count == 8'h00) || $past(wr))
    else $error("lower wrap did not set lower overflow flag");

  cascade_advance_a: assert property (
    (!split && l_wrap && !wr) |=> (s_r.upper_count == $past(s_r.upper_count) + 8'h01))
    else $error("upper counter did not advance on lower overflow");

  upper_rate_a: assert property (
    (split && s_r.ctrl[6:4] == `SEL_DIV32 && !tick_div32 && !wr) |=>
      $stable(s_r.upper_count))
    else $error("upper counter moved without its rate tick");

  upper_irq_gate_a: assert property (
    upper_overflow_irq |-> $past(s_r.stat[`BIT_UPPER_OVERFLOW_IRQ_ENABLE]))
    else $error("upper overflow request while disabled");

  lower_match_clear_a: assert property (
    (split && l_match && s_r.stat[`BIT_LOWER_MATCH_CLEAR_ENABLE] && !wr) |=>
      (s_r.lower_count == 8'h00 && s_r.stat[`BIT_LOWER_MATCH_FLAG]))
    else $error("lower match clear or flag missing");

  lower_no_set_a: assert property (
    (wr_stat && !flag_cur[0] && !flag_evt[0]) |=> !s_r.stat[`BIT_LOWER_MATCH_FLAG])
    else $error("software set lower match flag");

  upper_wrap_flag_a: assert property (
    u_wrap |=> s_r.stat[`BIT_UPPER_OVERFLOW_FLAG])
    else $error("upper wrap did not set upper overflow flag");

  upper_match_flag_a: assert property (
    u_match |=> (s_r.stat[`BIT_UPPER_MATCH_FLAG] && upper_match_irq))
    else $error("upper match flag or request missing");

  match_toggle_a: assert property (
    (u_match && !wr_ctrl) |=> (upper_toggle_pin != $past(upper_toggle_pin)))
    else $error("upper toggle pin did not toggle on match");

  lower_match_flag_a: assert property (
    (split && l_match) |=> (s_r.stat[`BIT_LOWER_MATCH_FLAG] && lower_match_irq))
    else $error("lower match flag or request missing");

  lower_irq_gate_a: assert property (
    lower_overflow_irq |-> $past(s_r.stat[`BIT_LOWER_OVERFLOW_IRQ_ENABLE]))
    else $error("lower overflow request while disabled");

  upper_match_clear_a: assert property (
    (u_clr && !wr) |=> (s_r.upper_count == 8'h00))
    else $error("upper counter not cleared on match");

  cascade_hold_a: assert property (
    (!split && !l_wrap && !l_clr && !wr) |=> $stable(s_r.upper_count))
    else $error("joined upper counter moved without lower overflow");

  prohibited_code_a: assert property (
    (!s_r.ctrl[2] && s_r.ctrl[1:0] != 2'b00 && !wr) |=> $stable(s_r.lower_count))
    else $error("lower counter moved on an unused select code");

  lower_rate_a: assert property (
    (s_r.ctrl[2:0] == `SEL_DIV4 && !tick_div4 && !wr) |=> $stable(s_r.lower_count))
    else $error("lower counter moved without its rate tick");

  event_edge_a: assert property (
    (s_r.ctrl[2:0] == `SEL_CASCADE_OR_EVENT && !ev_edge && !wr) |=> $stable(s_r.lower_count))
    else $error("lower counter moved without an event edge");

  cascade_overflow_c: cover property (!split ##0 u_wrap);
  cascade_match_c: cover property (!split ##0 j_match);
  split_match_toggle_c: cover property (split && u_match ##1 upper_match_irq);
  event_count_c: cover property (s_r.ctrl[2:0] == `SEL_CASCADE_OR_EVENT && l_tick);
  flag_clear_c: cover property (rd_stat && flag_cur[1] ##1 wr_stat && !wdata[3]);

endmodule : cascadable_timer_control_status

/* hdl/timer_params.svh */
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register byte addresses
`define ADDR_CLOCK_LEVEL_CONTROL 8'h00
`define ADDR_FLAG_ENABLE_STATUS 8'h04
`define ADDR_UPPER_COUNT 8'h08
`define ADDR_LOWER_COUNT 8'h0C
`define ADDR_UPPER_COMPARE 8'h10
`define ADDR_LOWER_COMPARE 8'h14

// reset values
`define RST_CONTROL 8'h00
`define RST_STATUS 8'h00
`define RST_COUNT 8'h00
`define RST_COMPARE 8'hFF

// control field positions
`define BIT_UPPER_TOGGLE_LEVEL 7
`define BIT_UPPER_SPLIT 6
`define BIT_LOWER_TOGGLE_LEVEL 3

// status field positions
`define BIT_UPPER_OVERFLOW_FLAG 7
`define BIT_UPPER_MATCH_FLAG 6
`define BIT_UPPER_OVERFLOW_IRQ_ENABLE 5
`define BIT_UPPER_MATCH_CLEAR_ENABLE 4
`define BIT_LOWER_OVERFLOW_FLAG 3
`define BIT_LOWER_MATCH_FLAG 2
`define BIT_LOWER_OVERFLOW_IRQ_ENABLE 1
`define BIT_LOWER_MATCH_CLEAR_ENABLE 0
`define STATUS_WRITABLE_MASK 8'h33

// clock select codes
`define SEL_CASCADE_OR_EVENT 3'h0
`define SEL_DIV32 3'h4
`define SEL_DIV16 3'h5
`define SEL_DIV4 3'h6
`define SEL_SUB_DIV4 3'h7

// prescaler divide ratios
`define DIV_RATIO_32 32
`define DIV_RATIO_16 16
`define DIV_RATIO_4 4
`define SUB_DIV_RATIO 4

`endif

/* hdl/timer_pkg.sv */
`include "timer_params.svh"

package timer_pkg;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [3:0] seen;
    logic [7:0] upper_count;
    logic [7:0] lower_count;
    logic [7:0] upper_compare_value;
    logic [7:0] lower_compare_value;
    logic upper_toggle_pin;
    logic lower_toggle_pin;
    logic ev_prev;
    logic [7:0] rdata;
    logic upper_ovf_req;
    logic lower_ovf_req;
    logic upper_match_req;
    logic lower_match_req;
  } timer_state_t;

  typedef struct packed {
    logic [4:0] div_cnt;
    logic [1:0] sub_cnt;
    logic sub_prev;
    logic tick_div32;
    logic tick_div16;
    logic tick_div4;
    logic tick_sub_div4;
  } presc_state_t;

endpackage : timer_pkg

/* hdl/clock_prescaler.sv */
`timescale 1ns/1ps
`include "timer_params.svh"

module clock_prescaler
  import timer_pkg::*;
#(
  parameter int DIV_W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // subclock level, synchronous to clk
  input wire logic sub_clk_in,
  // one-cycle rate ticks
  output logic tick_div32,
  output logic tick_div16,
  output logic tick_div4,
  output logic tick_sub_div4
);

  presc_state_t s_r;
  presc_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.div_cnt = s_r.div_cnt + 5'h01;
    s_nxt.tick_div32 = (32'(s_r.div_cnt) == `DIV_RATIO_32 - 1);
    s_nxt.tick_div16 = (32'(s_r.div_cnt[3:0]) == `DIV_RATIO_16 - 1);
    s_nxt.tick_div4 = (32'(s_r.div_cnt[1:0]) == `DIV_RATIO_4 - 1);
    s_nxt.sub_prev = sub_clk_in;
    s_nxt.tick_sub_div4 = 1'b0;
    // count subclock rising edges, tick every fourth
    if (sub_clk_in && !s_r.sub_prev) begin
      s_nxt.sub_cnt = s_r.sub_cnt + 2'h1;
      s_nxt.tick_sub_div4 = (32'(s_r.sub_cnt) == `SUB_DIV_RATIO - 1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_div32 = s_r.tick_div32;
  assign tick_div16 = s_r.tick_div16;
  assign tick_div4 = s_r.tick_div4;
  assign tick_sub_div4 = s_r.tick_sub_div4;

endmodule : clock_prescaler

/* verif/tb.sv */
`timescale 1ns/1ps
`include "timer_params.svh"

module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ev = 1'b0;
  logic ev_sel = 1'b0;
  logic ev_fs = 1'b0;
  logic sub = 1'b0;
  logic [1:0] sub_cnt = 2'h0;
  logic up_pin;
  logic lo_pin;
  logic [3:0] irq;
  int cnt[4];
  int snap[4];
  int fails = 0;
  int n_compared = 0;
  int seed = 80703;
  int k;
  logic [7:0] v;

  cascadable_timer_control_status uut (
    .clk(clk),
    .rstn(rstn),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .event_input_pin(ev),
    .event_edge_select(ev_sel),
    .event_pin_function_select(ev_fs),
    .sub_clk_in(sub),
    .upper_toggle_pin(up_pin),
    .lower_toggle_pin(lo_pin),
    .lower_overflow_irq(irq[0]),
    .upper_overflow_irq(irq[1]),
    .lower_match_irq(irq[2]),
    .upper_match_irq(irq[3])
  );

  initial begin
    forever #4 clk = ~clk;
  end

  // subclock rises every fourth cycle; irq pulses are tallied
  always @(posedge clk) begin
    sub_cnt <= sub_cnt + 2'h1;
    sub <= sub_cnt[1];
    for (int i = 0; i < 4; i++) begin
      if (irq[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
  end

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk8

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [7:0] got);
    n_compared++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      fails++;
      $display("[ERR] %s expected %0d..%0d seen %h", nm, lo, hi, got);
    end
  endtask : chk_rng

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk8(nm, exp, d);
  endtask : rd_chk

  task automatic rd_rng(input string nm, input logic [7:0] a, input int lo, input int hi);
    logic [7:0] d;
    rd_reg(a, d);
    chk_rng(nm, lo, hi, d);
  endtask : rd_rng

  // cycles per count for a select code, zero where it must not count
  function automatic int ratio(input int code);
    case (code)
      4: return `DIV_RATIO_32;
      5: return `DIV_RATIO_16;
      6: return `DIV_RATIO_4;
      7: return 4 * `SUB_DIV_RATIO;
      default: return 0;
    endcase
  endfunction : ratio

  function automatic int lo_of(input int code);
    return (ratio(code) == 0) ? 0 : 128 / ratio(code) - 1;
  endfunction : lo_of

  function automatic int hi_of(input int code);
    return (ratio(code) == 0) ? 0 : 136 / ratio(code) + 1;
  endfunction : hi_of

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("status reset", `ADDR_FLAG_ENABLE_STATUS, `RST_STATUS);
    rd_chk("control read", `ADDR_CLOCK_LEVEL_CONTROL, 8'h00);
    chk8("pins reset", 8'h00, {6'h0, up_pin, lo_pin});
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h88);
    chk8("pins both", 8'h03, {6'h0, up_pin, lo_pin});
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h80);
    chk8("pins upper", 8'h02, {6'h0, up_pin, lo_pin});
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h08);
    chk8("pins lower", 8'h01, {6'h0, up_pin, lo_pin});
    wr_reg(8'h1C, 8'hA5);
    rd_chk("unmapped", 8'h1C, 8'h00);
    wr_reg(`ADDR_FLAG_ENABLE_STATUS, 8'hFF);
    rd_chk("status write", `ADDR_FLAG_ENABLE_STATUS, `STATUS_WRITABLE_MASK);
    wr_reg(`ADDR_FLAG_ENABLE_STATUS, 8'h00);
    // every select code on the lower half, upper codes 4 to 7 only, in split mode
    for (int c = 0; c < 8; c++) begin
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'(((4 | (c & 3)) << 4) | c));
      wr_reg(`ADDR_UPPER_COUNT, 8'h00);
      wr_reg(`ADDR_LOWER_COUNT, 8'h00);
      repeat (128) @(posedge clk);
      rd_rng("upper rate", `ADDR_UPPER_COUNT, lo_of(4 | (c & 3)), hi_of(4 | (c & 3)));
      rd_rng("lower rate", `ADDR_LOWER_COUNT, lo_of(c), hi_of(c));
    end
    // event counting, rising then falling edges
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h40);
    @(posedge clk);
    ev_fs <= 1'b1;
    repeat (4) @(posedge clk);
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      ev_sel <= 1'(s);
      wr_reg(`ADDR_LOWER_COUNT, 8'h00);
      k = 1 + ($unsigned($random(seed)) % 8);
      repeat (k) begin
        @(posedge clk);
        ev <= 1'b1;
        repeat (2) @(posedge clk);
        ev <= 1'b0;
        repeat (3) @(posedge clk);
      end
      rd_chk("event count", `ADDR_LOWER_COUNT, 8'(k));
    end
    // pin function switched twice while the pin is low
    wr_reg(`ADDR_LOWER_COUNT, 8'h00);
    @(posedge clk);
    ev_fs <= 1'b0;
    repeat (4) @(posedge clk);
    ev_fs <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk("switch count", `ADDR_LOWER_COUNT, 8'h01);
    // wrap both halves, with and without overflow requests enabled
    for (int e = 0; e < 2; e++) begin
      v = (e == 1) ? 8'h22 : 8'h00;
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h01);
      wr_reg(`ADDR_FLAG_ENABLE_STATUS, v);
      wr_reg(`ADDR_UPPER_COUNT, 8'hFE);
      wr_reg(`ADDR_LOWER_COUNT, 8'hFE);
      snap = cnt;
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h66);
      repeat (40) @(posedge clk);
      #1;
      chk8("pins toggled", 8'h03, {6'h0, up_pin, lo_pin});
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h01);
      for (int i = 0; i < 4; i++) begin
        k = (i < 2) ? e : 1;
        chk_rng("irq pulses", k, k, 8'(cnt[i] - snap[i]));
      end
      wr_reg(`ADDR_FLAG_ENABLE_STATUS, v);
      rd_chk("flags kept", `ADDR_FLAG_ENABLE_STATUS, 8'hCC | v);
      wr_reg(`ADDR_FLAG_ENABLE_STATUS, v);
      rd_chk("flags cleared", `ADDR_FLAG_ENABLE_STATUS, v);
    end
    // compare match clears each half in split mode
    wr_reg(`ADDR_UPPER_COMPARE, 8'h03);
    wr_reg(`ADDR_LOWER_COMPARE, 8'h03);
    wr_reg(`ADDR_FLAG_ENABLE_STATUS, 8'h11);
    wr_reg(`ADDR_UPPER_COUNT, 8'h00);
    wr_reg(`ADDR_LOWER_COUNT, 8'h00);
    snap = cnt;
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h66);
    repeat (64) @(posedge clk);
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h01);
    rd_rng("upper cleared", `ADDR_UPPER_COUNT, 0, 3);
    rd_rng("lower cleared", `ADDR_LOWER_COUNT, 0, 3);
    rd_chk("match flags", `ADDR_FLAG_ENABLE_STATUS, 8'h55);
    chk_rng("upper matches", 3, 5, 8'(cnt[3] - snap[3]));
    chk_rng("lower matches", 3, 5, 8'(cnt[2] - snap[2]));
    wr_reg(`ADDR_FLAG_ENABLE_STATUS, 8'h00);
    rd_chk("match cleared", `ADDR_FLAG_ENABLE_STATUS, 8'h00);
    // cascade: upper advances on lower wrap
    wr_reg(`ADDR_UPPER_COMPARE, 8'hFF);
    wr_reg(`ADDR_LOWER_COMPARE, 8'hFF);
    wr_reg(`ADDR_UPPER_COUNT, 8'h00);
    wr_reg(`ADDR_LOWER_COUNT, 8'hFC);
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h06);
    repeat (40) @(posedge clk);
    wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h01);
    rd_chk("cascade upper", `ADDR_UPPER_COUNT, 8'h01);
    rd_rng("cascade lower", `ADDR_LOWER_COUNT, 4, 9);
    // joined match: upper holds without clear, both clear with it
    wr_reg(`ADDR_UPPER_COMPARE, 8'h00);
    wr_reg(`ADDR_LOWER_COMPARE, 8'h03);
    for (int e = 0; e < 2; e++) begin
      wr_reg(`ADDR_FLAG_ENABLE_STATUS, (e == 1) ? 8'h10 : 8'h00);
      wr_reg(`ADDR_UPPER_COUNT, 8'h00);
      wr_reg(`ADDR_LOWER_COUNT, 8'h00);
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h06);
      repeat (24) @(posedge clk);
      wr_reg(`ADDR_CLOCK_LEVEL_CONTROL, 8'h01);
      rd_chk("joined upper", `ADDR_UPPER_COUNT, 8'h00);
      rd_rng("joined lower", `ADDR_LOWER_COUNT, 5 * (1 - e), 8 - 5 * e);
      rd_chk("joined flags", `ADDR_FLAG_ENABLE_STATUS, (e == 1) ? 8'h50 : 8'h48);
    end
    repeat (4) begin
      v = 8'($random(seed));
      wr_reg(`ADDR_UPPER_COMPARE, v);
      rd_chk("upper compare", `ADDR_UPPER_COMPARE, v);
      wr_reg(`ADDR_LOWER_COMPARE, ~v);
      rd_chk("lower compare", `ADDR_LOWER_COMPARE, ~v);
    end
    finish_test();
  end
endmodule : tb
